// ==== scio_pkg.sv ====
package scio_pkg;

    typedef struct packed {
        logic [20:0] rsvd;
        logic do_no_ul_diag;
        logic [1:0] ul_report;
        logic us_report;
        logic [2:0] map_mode;
        logic do_source;
        logic ext_cfg_en;
        logic force_en;
        logic web_en;
    } scio_gen_ctrl_t;

    typedef enum logic [1:0] {
        SCIO_AUX_CFG,
        SCIO_AUX_FORCE_IN,
        SCIO_AUX_FORCE_OUT,
        SCIO_AUX_NONE
    } scio_aux_kind_t;

    typedef struct packed {
        logic valid;
        scio_aux_kind_t kind;
        logic [31:0] data;
    } scio_aux_req_t;

endpackage : scio_pkg

// ==== scio_plc_model.sv ====
`timescale 1ns/10ps
module scio_plc_model (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // bench commands
    input wire logic conn_req_in,
    input wire logic [15:0] out_image_set_in,
    // toward the block
    output logic conn_active_out,
    output logic [15:0] out_image_out
);
    // image is only sent while connected, so stale data never leaks
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            conn_active_out <= 1'b0;
            out_image_out <= 16'h0000;
        end else begin
            conn_active_out <= conn_req_in;
            out_image_out <= conn_req_in ? out_image_set_in : 16'h0000;
        end
    end
endmodule : scio_plc_model

// ==== scio_regs.svh ====
`ifndef SCIO_REGS_SVH
`define SCIO_REGS_SVH

// register byte offsets
`define SCIO_GEN_CTRL_OFS 8'h00
`define SCIO_IN_FILT_OFS 8'h04
`define SCIO_IN_LOGIC_OFS 8'h08
`define SCIO_MAP_LO_OFS 8'h0C
`define SCIO_MAP_HI_OFS 8'h10
`define SCIO_STATUS_OFS 8'h14
`define SCIO_IMAGE_OFS 8'h18
`define SCIO_FORCE_IN_OFS 8'h1C
`define SCIO_FORCE_OUT_OFS 8'h20

// reset values and write masks
`define SCIO_GEN_CTRL_RST 32'h000004A1
`define SCIO_GEN_CTRL_WMASK 32'h000007FF
`define SCIO_IN_FILT_RST 32'h006DB6DB
`define SCIO_IN_FILT_WMASK 32'h00FFFFFF
`define SCIO_IN_LOGIC_RST 32'h00000000
`define SCIO_IN_LOGIC_WMASK 32'h0000FFFF
`define SCIO_MAP_LO_RST 32'h76543210
`define SCIO_MAP_HI_RST 32'hFEDCBA98

// mapping mode codes
`define SCIO_MAP_M1 3'h1
`define SCIO_MAP_M2 3'h2
`define SCIO_MAP_M3 3'h3
`define SCIO_MAP_M4 3'h4
`define SCIO_MAP_M5 3'h5

// load supply report modes
`define SCIO_UL_OFF 2'h0
`define SCIO_UL_ON 2'h1
`define SCIO_UL_AUTO 2'h2

// input filter codes
`define SCIO_FILT_OFF 3'h0
`define SCIO_FILT_1MS 3'h1
`define SCIO_FILT_2MS 3'h2
`define SCIO_FILT_3MS 3'h3
`define SCIO_FILT_6MS 3'h4
`define SCIO_FILT_10MS 3'h5
`define SCIO_FILT_15MS 3'h6

// timing
`define SCIO_CLK_PERIOD_NS 40
`define SCIO_MS_NS 1000000
`define SCIO_CYC_PER_MS (`SCIO_MS_NS / `SCIO_CLK_PERIOD_NS)

`endif

// ==== scio_status_control.sv ====
`timescale 1ns/10ps
`include "scio_regs.svh"

module scio_status_control
    import scio_pkg::*;
#(
    parameter int CYC_PER_MS = `SCIO_CYC_PER_MS
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // controller side
    input wire logic conn_active_in,
    input wire logic [15:0] plc_out_image_in,
    output logic [15:0] plc_in_image_out,
    // auxiliary interfaces
    input scio_aux_req_t aux_req_in,
    output logic aux_accept_out,
    output logic aux_reject_out,
    output logic web_serve_en_out,
    // ports and channels
    input wire logic [7:0] iol_mode_in,
    input wire logic [7:0] port_sub_do_in,
    input wire logic [15:0] digital_input_in,
    output logic [7:0] first_port_channel_do_out,
    output logic [15:0] led_out,
    output logic [7:0] sensor_supply_out,
    // supplies and diagnostics
    input wire logic us_fault_in,
    input wire logic ul_present_in,
    output logic us_fault_report_out,
    output logic ul_fault_report_out,
    output logic [7:0] do_fault_out,
    output logic param_fault_out
);

    scio_gen_ctrl_t gen_ctrl_reg;
    scio_gen_ctrl_t ext_ctrl_reg;
    scio_gen_ctrl_t ctrl_eff;
    logic ext_valid_reg;
    logic [23:0] in_filt_reg;
    logic [15:0] in_logic_reg;
    logic [63:0] user_map_reg;
    logic [31:0] force_in_reg;
    logic [31:0] force_out_reg;
    logic conn_prev_reg;
    logic new_conn;
    logic ul_prev_reg;
    logic ul_seen_reg;
    logic [15:0] filt_reg;
    logic [15:0] reported;
    logic [15:0] in_img_next;
    logic [15:0] out_img_eff;
    logic [15:0] sc_bit;
    logic [15:0] fin_mask;
    logic [15:0] fout_mask;
    logic dup_found;
    logic wb_req;
    logic [31:0] rd_data;

    // bytewise write merge under the wishbone select lines
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel, input logic [31:0] wmask);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return (res & wmask) | (old_v & ~wmask);
    endfunction : wb_merge

    // channel c: port c/2, first channel when c is even
    function automatic logic [3:0] map_bit(input logic [2:0] mode, input logic [3:0] ch,
                                           input logic [3:0] user);
        case (mode)
            `SCIO_MAP_M1: map_bit = ch;
            `SCIO_MAP_M3: map_bit = 4'hF - ch;
            `SCIO_MAP_M4: map_bit = {~ch[0], ch[3:1]};
            `SCIO_MAP_M5: map_bit = user;
            default: map_bit = {ch[0], ch[3:1]};
        endcase
    endfunction : map_bit

    function automatic logic [4:0] filt_ms(input logic [2:0] code);
        case (code)
            `SCIO_FILT_OFF: filt_ms = 5'h00;
            `SCIO_FILT_1MS: filt_ms = 5'h01;
            `SCIO_FILT_2MS: filt_ms = 5'h02;
            `SCIO_FILT_3MS: filt_ms = 5'h03;
            `SCIO_FILT_6MS: filt_ms = 5'h06;
            `SCIO_FILT_10MS: filt_ms = 5'h0A;
            default: filt_ms = 5'h0F;
        endcase
    endfunction : filt_ms

    assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign new_conn = conn_active_in & ~conn_prev_reg;
    assign ctrl_eff = ext_valid_reg ? ext_ctrl_reg : gen_ctrl_reg;
    assign fin_mask = ctrl_eff.force_en ? force_in_reg[15:0] : 16'h0000;
    assign fout_mask = ctrl_eff.force_en ? force_out_reg[15:0] : 16'h0000;
    assign sensor_supply_out = 8'hFF;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            gen_ctrl_reg <= scio_gen_ctrl_t'(`SCIO_GEN_CTRL_RST);
            in_filt_reg <= 24'(`SCIO_IN_FILT_RST);
            in_logic_reg <= 16'(`SCIO_IN_LOGIC_RST);
            user_map_reg <= {`SCIO_MAP_HI_RST, `SCIO_MAP_LO_RST};
        end else if (wb_req && wb_we_in) begin
            case (wb_adr_in)
                `SCIO_GEN_CTRL_OFS: begin
                    gen_ctrl_reg <= scio_gen_ctrl_t'(wb_merge(gen_ctrl_reg, wb_dat_in,
                                                    wb_sel_in, `SCIO_GEN_CTRL_WMASK));
                end
                `SCIO_IN_FILT_OFS: begin
                    in_filt_reg <= 24'(wb_merge({8'h00, in_filt_reg}, wb_dat_in, wb_sel_in,
                                                `SCIO_IN_FILT_WMASK));
                end
                `SCIO_IN_LOGIC_OFS: begin
                    in_logic_reg <= 16'(wb_merge({16'h0000, in_logic_reg}, wb_dat_in, wb_sel_in,
                                                 `SCIO_IN_LOGIC_WMASK));
                end
                `SCIO_MAP_LO_OFS: begin
                    user_map_reg[31:0] <= wb_merge(user_map_reg[31:0], wb_dat_in, wb_sel_in,
                                                   32'hFFFFFFFF);
                end
                `SCIO_MAP_HI_OFS: begin
                    user_map_reg[63:32] <= wb_merge(user_map_reg[63:32], wb_dat_in, wb_sel_in,
                                                    32'hFFFFFFFF);
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (wb_adr_in)
            `SCIO_GEN_CTRL_OFS: rd_data = 32'(gen_ctrl_reg);
            `SCIO_IN_FILT_OFS: rd_data = {8'h00, in_filt_reg};
            `SCIO_IN_LOGIC_OFS: rd_data = {16'h0000, in_logic_reg};
            `SCIO_MAP_LO_OFS: rd_data = user_map_reg[31:0];
            `SCIO_MAP_HI_OFS: rd_data = user_map_reg[63:32];
            `SCIO_STATUS_OFS: rd_data = {16'h0000, do_fault_out, 2'h0, ul_fault_report_out,
                                         us_fault_report_out, ul_seen_reg, conn_active_in,
                                         ext_valid_reg, param_fault_out};
            `SCIO_IMAGE_OFS: rd_data = {out_img_eff, plc_in_image_out};
            `SCIO_FORCE_IN_OFS: rd_data = force_in_reg;
            `SCIO_FORCE_OUT_OFS: rd_data = force_out_reg;
            default: rd_data = 32'h00000000;
        endcase
    end

    // unmapped addresses still ack, reading zero
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            wb_ack_out <= wb_req;
            wb_dat_out <= (wb_req && !wb_we_in) ? rd_data : 32'h00000000;
        end
    end

    // auxiliary configuration and forcing
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ext_valid_reg <= 1'b0;
            ext_ctrl_reg <= scio_gen_ctrl_t'(`SCIO_GEN_CTRL_RST);
            force_in_reg <= 32'h00000000;
            force_out_reg <= 32'h00000000;
            aux_accept_out <= 1'b0;
            aux_reject_out <= 1'b0;
            conn_prev_reg <= 1'b0;
        end else begin
            conn_prev_reg <= conn_active_in;
            aux_accept_out <= 1'b0;
            aux_reject_out <= 1'b0;
            if (new_conn) begin
                ext_valid_reg <= 1'b0;
            end
            if (aux_req_in.valid) begin
                case (aux_req_in.kind)
                    SCIO_AUX_CFG: begin
                        if (ctrl_eff.ext_cfg_en && !conn_active_in) begin
                            ext_ctrl_reg <= scio_gen_ctrl_t'(aux_req_in.data &
                                                            `SCIO_GEN_CTRL_WMASK);
                            ext_valid_reg <= 1'b1;
                            aux_accept_out <= 1'b1;
                        end else begin
                            aux_reject_out <= 1'b1;
                        end
                    end
                    SCIO_AUX_FORCE_IN, SCIO_AUX_FORCE_OUT: begin
                        if (ctrl_eff.force_en) begin
                            if (aux_req_in.kind == SCIO_AUX_FORCE_IN) begin
                                force_in_reg <= aux_req_in.data;
                            end else begin
                                force_out_reg <= aux_req_in.data;
                            end
                            aux_accept_out <= 1'b1;
                        end else begin
                            aux_reject_out <= 1'b1;
                        end
                    end
                    default: aux_reject_out <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            web_serve_en_out <= 1'b1;
        end else begin
            web_serve_en_out <= ctrl_eff.web_en;
        end
    end

    // one counter per input; exact cycle count rather than a shared ms tick
    generate
        for (genvar c = 0; c < 16; c++) begin : g_filt
            logic [23:0] cnt_reg;
            logic [23:0] thr;
            logic lvl_reg;
            assign thr = 24'(filt_ms(in_filt_reg[(c/2)*3 +: 3]) * CYC_PER_MS);
            assign filt_reg[c] = lvl_reg;
            always_ff @(posedge ref_clk_in) begin
                if (srst_in) begin
                    cnt_reg <= 24'h000000;
                    lvl_reg <= 1'b0;
                end else if (thr == 24'h000000) begin
                    cnt_reg <= 24'h000000;
                    lvl_reg <= digital_input_in[c];
                end else if (digital_input_in[c] == lvl_reg) begin
                    cnt_reg <= 24'h000000;
                end else if (cnt_reg + 24'h000001 >= thr) begin
                    cnt_reg <= 24'h000000;
                    lvl_reg <= digital_input_in[c];
                end else begin
                    cnt_reg <= cnt_reg + 24'h000001;
                end
            end
        end
    endgenerate

    assign reported = filt_reg ^ in_logic_reg;

    always_comb begin
        dup_found = 1'b0;
        for (int i = 0; i < 16; i++) begin
            for (int j = i + 1; j < 16; j++) begin
                if (user_map_reg[i*4 +: 4] == user_map_reg[j*4 +: 4]) begin
                    dup_found = 1'b1;
                end
            end
        end
    end

    always_comb begin
        in_img_next = 16'h0000;
        out_img_eff = (plc_out_image_in & ~fout_mask) | (force_out_reg[31:16] & fout_mask);
        for (int i = 0; i < 16; i++) begin
            if (!(i % 2 == 0 && iol_mode_in[i/2])) begin
                in_img_next[map_bit(ctrl_eff.map_mode, 4'(i), user_map_reg[i*4 +: 4])] =
                    reported[i];
            end
            sc_bit[i] = out_img_eff[map_bit(ctrl_eff.map_mode, 4'(i), user_map_reg[i*4 +: 4])];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            plc_in_image_out <= 16'h0000;
            led_out <= 16'h0000;
            param_fault_out <= 1'b0;
        end else begin
            plc_in_image_out <= (in_img_next & ~fin_mask) | (force_in_reg[31:16] & fin_mask);
            led_out <= filt_reg;
            param_fault_out <= (ctrl_eff.map_mode == `SCIO_MAP_M5) && dup_found;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            first_port_channel_do_out <= 8'h00;
        end else begin
            for (int p = 0; p < 8; p++) begin
                if (iol_mode_in[p]) begin
                    first_port_channel_do_out[p] <= 1'b0;
                end else if (ctrl_eff.do_source) begin
                    first_port_channel_do_out[p] <= sc_bit[p*2];
                end else begin
                    first_port_channel_do_out[p] <= port_sub_do_in[p];
                end
            end
        end
    end

    // supply supervision
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ul_prev_reg <= 1'b0;
            ul_seen_reg <= 1'b0;
            us_fault_report_out <= 1'b0;
            ul_fault_report_out <= 1'b0;
            do_fault_out <= 8'h00;
        end else begin
            ul_prev_reg <= ul_present_in;
            if (ul_present_in && !ul_prev_reg) begin
                ul_seen_reg <= 1'b1;
            end
            us_fault_report_out <= ctrl_eff.us_report & us_fault_in;
            ul_fault_report_out <= !ul_present_in &&
                ((ctrl_eff.ul_report == `SCIO_UL_ON) ||
                 (ctrl_eff.ul_report == `SCIO_UL_AUTO && ul_seen_reg));
            do_fault_out <= ctrl_eff.do_no_ul_diag ?
                (first_port_channel_do_out & {8{~ul_present_in}}) : 8'h00;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);

    web_gate_a: assert property (!ctrl_eff.web_en |=> !web_serve_en_out)
        else $error("web pages served while disabled");
    force_refuse_a: assert property (aux_req_in.valid && aux_req_in.kind != SCIO_AUX_CFG &&
        !ctrl_eff.force_en |=> aux_reject_out && $stable(force_in_reg))
        else $error("forcing accepted while disabled");
    ext_gate_a: assert property (aux_req_in.valid && aux_req_in.kind == SCIO_AUX_CFG &&
        conn_active_in |=> aux_reject_out && !aux_accept_out)
        else $error("external config accepted during connection");
    new_conn_a: assert property (new_conn |=> !ext_valid_reg)
        else $error("external config kept after new connection");
    dup_fault_a: assert property (ctrl_eff.map_mode == `SCIO_MAP_M5 && dup_found
        |=> param_fault_out)
        else $error("duplicate assignment not flagged");
    fixed_ignore_a: assert property (ctrl_eff.map_mode != `SCIO_MAP_M5
        |=> !param_fault_out)
        else $error("fault raised in fixed mode");
    src_port_a: assert property (!ctrl_eff.do_source && !iol_mode_in[0]
        |=> first_port_channel_do_out[0] == $past(port_sub_do_in[0]))
        else $error("first channel output not from submodule");
    iol_untouched_a: assert property (iol_mode_in[0]
        |=> !first_port_channel_do_out[0])
        else $error("IO-Link channel driven by output source");
    do_diag_a: assert property (ctrl_eff.do_no_ul_diag && first_port_channel_do_out[0] &&
        !ul_present_in |=> do_fault_out[0])
        else $error("missing output diagnostic");
    ul_auto_a: assert property (ctrl_eff.ul_report == `SCIO_UL_AUTO && !ul_seen_reg
        |=> !ul_fault_report_out)
        else $error("auto supervision active before first rise");
    us_gate_a: assert property (!ctrl_eff.us_report |=> !us_fault_report_out)
        else $error("logic supply fault reported while disabled");
    sensor_on_a: assert property (sensor_supply_out == 8'hFF)
        else $error("sensor supply switched off");
    nc_invert_a: assert property (ctrl_eff.map_mode == `SCIO_MAP_M1 && !iol_mode_in[0] &&
        !fin_mask[0] |=> plc_in_image_out[0] == ($past(filt_reg[0]) ^ $past(in_logic_reg[0])))
        else $error("input logic not applied");
    led_phys_a: assert property (##1 led_out == $past(filt_reg))
        else $error("indicator not physical level");
    filt_hold_a: assert property (g_filt[0].thr != 24'h000000 &&
        digital_input_in[0] != filt_reg[0] && g_filt[0].cnt_reg + 24'h000001 < g_filt[0].thr
        |=> filt_reg[0] == $past(filt_reg[0]))
        else $error("filter updated early");

    new_conn_c: cover property (new_conn && ext_valid_reg);
    dup_fault_c: cover property (param_fault_out);
    force_ok_c: cover property (aux_accept_out && ctrl_eff.force_en);
    do_fault_c: cover property (do_fault_out != 8'h00);

endmodule : scio_status_control

// ==== scio_status_control_tb.sv ====
`timescale 1ns/10ps
`include "scio_regs.svh"
module scio_status_control_tb;
    import scio_pkg::*;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, acc, rej, web, pflt, usr, ulr, conn;
    logic [7:0] adr = 8'h00, iol = 8'h00, psub = 8'h00, fdo, ssup, dflt;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [15:0] din = 16'h0000, plc_set = 16'h0000, img_i, led, plc_img;
    logic usf = 1'b0, ulp = 1'b1, conn_req = 1'b0;
    scio_aux_req_t aux = '0;
    int mismatches = 0;
    int n_compared = 0;
    logic [15:0] exp_m [5] = '{16'h0002, 16'h0100, 16'h4000, 16'h0001, 16'h0001};

    always #20 ref_clk_in = ~ref_clk_in;

    scio_status_control #(.CYC_PER_MS(4)) uut (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
        .wb_dat_out(dat_o), .wb_ack_out(ack), .conn_active_in(conn),
        .plc_out_image_in(plc_img), .plc_in_image_out(img_i), .aux_req_in(aux),
        .aux_accept_out(acc), .aux_reject_out(rej), .web_serve_en_out(web),
        .iol_mode_in(iol), .port_sub_do_in(psub), .digital_input_in(din),
        .first_port_channel_do_out(fdo), .led_out(led), .sensor_supply_out(ssup),
        .us_fault_in(usf), .ul_present_in(ulp), .us_fault_report_out(usr),
        .ul_fault_report_out(ulr), .do_fault_out(dflt), .param_fault_out(pflt)
    );

    scio_plc_model plc (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .conn_req_in(conn_req),
        .out_image_set_in(plc_set), .conn_active_out(conn), .out_image_out(plc_img)
    );

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // request held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge ref_clk_in); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk("register", rdat, e);
    endtask : rd

    task automatic ax(input scio_aux_kind_t k, input logic [31:0] d, input logic e);
        @(posedge ref_clk_in);
        aux <= '{1'b1, k, d};
        @(posedge ref_clk_in);
        aux <= '0;
        #1;
        chk("accept", acc, e);
        chk("reject", rej, !e);
    endtask : ax

    task automatic st(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : st

    initial begin
        #400000;
        mismatches++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        st(1);
        chk("web", web, 1'b1);
        chk("sensor", ssup, 8'hFF);
        rd(`SCIO_GEN_CTRL_OFS, `SCIO_GEN_CTRL_RST);
        rd(`SCIO_IN_FILT_OFS, `SCIO_IN_FILT_RST);
        rd(`SCIO_IN_LOGIC_OFS, 32'h0);
        rd(8'hFC, 32'h0);
        ax(SCIO_AUX_FORCE_IN, 32'h00010001, 1'b0);
        ax(SCIO_AUX_NONE, 32'h0, 1'b0);
        ax(SCIO_AUX_CFG, 32'h000004A4, 1'b0);
        wb(1'b1, `SCIO_GEN_CTRL_OFS, 32'h000004A7);
        ax(SCIO_AUX_FORCE_OUT, 32'h0, 1'b1);
        ax(SCIO_AUX_CFG, 32'h000004A4, 1'b1);
        st(2);
        chk("web", web, 1'b0);
        @(posedge ref_clk_in) conn_req <= 1'b1;
        st(4);
        ax(SCIO_AUX_CFG, 32'h000004A4, 1'b0);
        rd(`SCIO_GEN_CTRL_OFS, 32'h000004A7);
        chk("web", web, 1'b1);
        wb(1'b1, `SCIO_IN_FILT_OFS, 32'h0);
        @(posedge ref_clk_in) din <= 16'h0002;
        // swapped user map must not disturb fixed layouts
        wb(1'b1, `SCIO_MAP_LO_OFS, 32'h76543201);
        for (int m = 1; m <= 5; m++) begin
            wb(1'b1, `SCIO_GEN_CTRL_OFS, 32'h00000481 | (m << 4));
            st(4);
            chk("image", img_i, exp_m[m-1]);
        end
        chk("pfault", pflt, 1'b0);
        wb(1'b1, `SCIO_MAP_LO_OFS, 32'h76543200);
        st(3);
        chk("pfault", pflt, 1'b1);
        wb(1'b1, `SCIO_GEN_CTRL_OFS, 32'h00000491);
        wb(1'b1, `SCIO_IN_LOGIC_OFS, 32'h00000002);
        st(4);
        chk("image", img_i, 16'h0000);
        chk("led", led[1], 1'b1);
        wb(1'b1, `SCIO_IN_LOGIC_OFS, 32'h0);
        st(4);
        chk("image", img_i, 16'h0002);
        wb(1'b1, `SCIO_IN_FILT_OFS, 32'h00000001);
        @(posedge ref_clk_in) din <= 16'h0003;
        st(2);
        chk("image", img_i, 16'h0002);
        st(12);
        chk("image", img_i, 16'h0003);
        @(posedge ref_clk_in) iol <= 8'h01;
        st(4);
        chk("image", img_i, 16'h0002);
        @(posedge ref_clk_in);
        iol <= 8'h00;
        psub <= 8'h01;
        st(4);
        chk("do", fdo[0], 1'b1);
        wb(1'b1, `SCIO_GEN_CTRL_OFS, 32'h000004B9);
        psub <= 8'h00;
        plc_set <= 16'h8000;
        st(4);
        chk("do", fdo[0], 1'b1);
        @(posedge ref_clk_in);
        ulp <= 1'b0;
        usf <= 1'b1;
        st(4);
        chk("dofault", dflt[0], 1'b1);
        chk("ulrep", ulr, 1'b0);
        chk("usrep", usr, 1'b1);
        wb(1'b1, `SCIO_GEN_CTRL_OFS, 32'h00000439);
        st(4);
        chk("usrep", usr, 1'b0);
        // second reset with load supply absent: auto mode must wait for a rise
        @(posedge ref_clk_in) srst_in <= 1'b1;
        st(2);
        @(posedge ref_clk_in) srst_in <= 1'b0;
        wb(1'b1, `SCIO_GEN_CTRL_OFS, 32'h000001A1);
        st(3);
        chk("ulrep", ulr, 1'b1);
        wb(1'b1, `SCIO_GEN_CTRL_OFS, 32'h000002A1);
        st(3);
        chk("ulrep", ulr, 1'b0);
        @(posedge ref_clk_in) ulp <= 1'b1;
        @(posedge ref_clk_in) ulp <= 1'b0;
        st(3);
        chk("ulrep", ulr, 1'b1);
        conclude();
    end
endmodule : scio_status_control_tb
